/* rtl/ppb_pkg.sv */
// Shared constants and types for the bridge command and address decode
`default_nettype none
package ppb_pkg;
    // ************************************************************
    // Bus commands
    // ************************************************************
    typedef enum logic [3:0] {
        CMD_INT_ACK = 4'h0,
        CMD_SPECIAL = 4'h1,
        CMD_IO_RD = 4'h2,
        CMD_IO_WR = 4'h3,
        CMD_RSV_4 = 4'h4,
        CMD_RSV_5 = 4'h5,
        CMD_MEM_RD = 4'h6,
        CMD_MEM_WR = 4'h7,
        CMD_RSV_8 = 4'h8,
        CMD_RSV_9 = 4'h9,
        CMD_CFG_RD = 4'hA,
        CMD_CFG_WR = 4'hB,
        CMD_MEM_RD_MULT = 4'hC,
        CMD_DUAL_ADDR = 4'hD,
        CMD_MEM_RD_LINE = 4'hE,
        CMD_MEM_WR_INV = 4'hF
    } ppb_cmd_type;

    // ************************************************************
    // Decoder states
    // ************************************************************
    typedef enum logic [0:0] {
        ST_FIRST = 1'b0,
        ST_SECOND = 1'b1
    } ppb_state_type;

    // ************************************************************
    // Address fields
    // ************************************************************
    localparam logic [1:0] CFG_TYPE0 = 2'h0;
    localparam logic [1:0] CFG_TYPE1 = 2'h1;
    localparam logic [1:0] BURST_LINEAR = 2'h0;
    localparam int CFG_SPECIAL_HI = 15;
    localparam int CFG_SPECIAL_LO = 2;
    // Device 1F, function 7, register 0 marks a special-cycle request
    localparam logic [13:0] CFG_SPECIAL_CODE = 14'h3FC0;
    localparam logic BUS_PRIMARY = 1'b0;
    localparam logic BUS_SECONDARY = 1'b1;

    // ************************************************************
    // Data buffers
    // ************************************************************
    localparam int BUF_BYTES = 128;
    localparam int BUF_COUNT = 4;
    localparam logic [1:0] BUF_RD_DOWN = 2'h0;
    localparam logic [1:0] BUF_RD_UP = 2'h1;
    localparam logic [1:0] BUF_WR_DOWN = 2'h2;
    localparam logic [1:0] BUF_WR_UP = 2'h3;
endpackage : ppb_pkg
`default_nettype wire

/* rtl/ppb_dec_if.sv */
// Decoded address-phase results from one bus decoder to the bridge core
`default_nettype none
interface ppb_dec_if;
    logic done;
    logic dual;
    logic [3:0] cmd;
    logic [63:0] addr;
    logic badBurst;
    logic cfgType0;
    logic cfgType1;
    logic specialReq;

    modport dec (output done, dual, cmd, addr, badBurst, cfgType0, cfgType1, specialReq);
    modport core (input done, dual, cmd, addr, badBurst, cfgType0, cfgType1, specialReq);
endinterface : ppb_dec_if
`default_nettype wire

/* rtl/ppb_addr_decode.sv */
// Address-phase decoder for one bus side, single and dual address
`default_nettype none
module ppb_addr_decode (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bus sampled on the side's own clock edge
    input wire logic step,
    input wire logic frameN,
    input wire logic [31:0] ad,
    input wire logic [3:0] cbeN,
    // Decode result
    ppb_dec_if.dec dec
);
    // ************************************************************
    // Phase tracking
    // ************************************************************
    ppb_pkg::ppb_state_type state;
    ppb_pkg::ppb_state_type next_state;
    logic prevFrameN;
    logic [31:0] lowAddr;
    wire logic [3:0] cmdNow = ~cbeN;
    wire logic frameStart = step && prevFrameN && !frameN;
    wire logic isDual = (cmdNow == ppb_pkg::CMD_DUAL_ADDR);
    wire logic singleDone = frameStart && !isDual;
    wire logic secondDone = step && (state == ppb_pkg::ST_SECOND);
    wire logic isCfgWr = (cmdNow == ppb_pkg::CMD_CFG_WR);
    wire logic specialHit =
        (ad[ppb_pkg::CFG_SPECIAL_HI:ppb_pkg::CFG_SPECIAL_LO] == ppb_pkg::CFG_SPECIAL_CODE);

    always_comb
    begin
        next_state = state;
        case (state)
            ppb_pkg::ST_FIRST:
            begin
                if (frameStart && isDual)
                begin
                    next_state = ppb_pkg::ST_SECOND;
                end
            end
            ppb_pkg::ST_SECOND:
            begin
                if (step)
                begin
                    next_state = ppb_pkg::ST_FIRST;
                end
            end
            default:
            begin
                next_state = ppb_pkg::ST_FIRST;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= ppb_pkg::ST_FIRST;
            prevFrameN <= 1'b1;
            lowAddr <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            if (step)
            begin
                prevFrameN <= frameN;
            end
            if (frameStart)
            begin
                lowAddr <= ad;
            end
        end
    end

    // ************************************************************
    // Results, one pulse per address decode
    // ************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            dec.done <= 1'b0;
            dec.dual <= 1'b0;
            dec.cmd <= 4'h0;
            dec.addr <= 64'h0000_0000_0000_0000;
            dec.badBurst <= 1'b0;
            dec.cfgType0 <= 1'b0;
            dec.cfgType1 <= 1'b0;
            dec.specialReq <= 1'b0;
        end
        else
        begin
            dec.done <= singleDone || secondDone;
            if (singleDone)
            begin
                // Whole address and command in one phase
                dec.dual <= 1'b0;
                dec.cmd <= cmdNow;
                dec.addr <= {32'h0000_0000, ad};
                dec.badBurst <= (ad[1:0] != ppb_pkg::BURST_LINEAR);
                dec.cfgType0 <= (ad[1:0] == ppb_pkg::CFG_TYPE0);
                dec.cfgType1 <= (ad[1:0] == ppb_pkg::CFG_TYPE1);
                dec.specialReq <= isCfgWr && (ad[1:0] == ppb_pkg::CFG_TYPE1) && specialHit;
            end
            else if (secondDone)
            begin
                // Second phase: real command, high half
                dec.dual <= 1'b1;
                dec.cmd <= cmdNow;
                dec.addr <= {ad, lowAddr};
                dec.badBurst <= (lowAddr[1:0] != ppb_pkg::BURST_LINEAR);
                dec.cfgType0 <= 1'b0;
                dec.cfgType1 <= 1'b0;
                dec.specialReq <= 1'b0;
            end
        end
    end
endmodule : ppb_addr_decode
`default_nettype wire

/* rtl/ppb_bridge_decode.sv */
// Bridge command and address decode with direction buffers
`default_nettype none
module ppb_bridge_decode #(
    parameter int BUF_BYTES = ppb_pkg::BUF_BYTES
) (
    // Clock and reset (primary clock)
    input wire logic clk_sys,
    input wire logic rst_n,
    // Primary bus
    input wire logic priFrameN,
    input wire logic [31:0] priAd,
    input wire logic [3:0] priCbeN,
    // Secondary bus
    input wire logic secondary_side_clock_in,
    input wire logic secFrameN,
    input wire logic [31:0] secAd,
    input wire logic [3:0] secCbeN,
    // Prefetchable window
    input wire logic [63:0] prefBase,
    input wire logic [63:0] prefLimit,
    // Master issue request
    input wire logic issueReq,
    input wire logic issueBus,
    input wire logic [3:0] issueCmd,
    input wire logic issueType1,
    output logic issueGrant,
    output logic issueDeny,
    // Claim results
    output logic priClaim,
    output logic priDisconnect,
    output logic priFwdDown,
    output logic secClaim,
    output logic secDisconnect,
    output logic secFwdUp,
    output logic [3:0] claimCmd,
    output logic [63:0] claimAddr,
    output logic specialOnPri,
    output logic specialOnSec,
    // Data buffers
    input wire logic bufWrEn,
    input wire logic [1:0] bufId,
    input wire logic [$clog2(BUF_BYTES/4)-1:0] bufIndex,
    input wire logic [31:0] bufWrData,
    output logic [31:0] bufRdData
);
    localparam int BUF_WORDS = BUF_BYTES / 4;

    // Word index must cover the array exactly, so a power-of-two size
    if (BUF_BYTES < 8 || (BUF_BYTES % 4) != 0 || (BUF_BYTES & (BUF_BYTES - 1)) != 0)
    begin : g_bad_buf
        $error("BUF_BYTES must be a power of two, at least 8");
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Second stage only is read; the first is a metastability guard
    logic [36:0] priMeta;
    logic [36:0] priSync;
    logic [37:0] secMeta;
    logic [37:0] secSync;
    logic secClkLast;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            priMeta <= {37{1'b1}};
            priSync <= {37{1'b1}};
            secMeta <= {38{1'b1}};
            secSync <= {38{1'b1}};
            secClkLast <= 1'b1;
        end
        else
        begin
            priMeta <= {priFrameN, priCbeN, priAd};
            priSync <= priMeta;
            secMeta <= {secondary_side_clock_in, secFrameN, secCbeN, secAd};
            secSync <= secMeta;
            secClkLast <= secSync[37];
        end
    end

    // Secondary side advances only on its own clock's rising edge
    wire logic secStep = secSync[37] && !secClkLast;
    wire logic priStep = 1'b1;

    // ************************************************************
    // Address decoders
    // ************************************************************
    ppb_dec_if priDec ();
    ppb_dec_if secDec ();

    ppb_addr_decode u_pri_dec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .step(priStep),
        .frameN(priSync[36]),
        .ad(priSync[31:0]),
        .cbeN(priSync[35:32]),
        .dec(priDec.dec)
    );

    ppb_addr_decode u_sec_dec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .step(secStep),
        .frameN(secSync[36]),
        .ad(secSync[31:0]),
        .cbeN(secSync[35:32]),
        .dec(secDec.dec)
    );

    // ************************************************************
    // Command tables
    // ************************************************************
    function automatic logic fwdCmd(input logic [3:0] cmd);
        fwdCmd = (cmd == ppb_pkg::CMD_IO_RD) || (cmd == ppb_pkg::CMD_IO_WR)
            || (cmd == ppb_pkg::CMD_MEM_RD) || (cmd == ppb_pkg::CMD_MEM_WR)
            || (cmd == ppb_pkg::CMD_MEM_RD_MULT) || (cmd == ppb_pkg::CMD_MEM_RD_LINE)
            || (cmd == ppb_pkg::CMD_MEM_WR_INV) || (cmd == ppb_pkg::CMD_DUAL_ADDR);
    endfunction : fwdCmd

    function automatic logic memCmd(input logic [3:0] cmd);
        memCmd = (cmd == ppb_pkg::CMD_MEM_RD) || (cmd == ppb_pkg::CMD_MEM_WR)
            || (cmd == ppb_pkg::CMD_MEM_RD_MULT) || (cmd == ppb_pkg::CMD_MEM_RD_LINE)
            || (cmd == ppb_pkg::CMD_MEM_WR_INV);
    endfunction : memCmd

    // Reserved, interrupt acknowledge and special fall to the default 0
    function automatic logic targetOk(input logic bus, input logic [3:0] cmd,
                                      input logic type1);
        if (fwdCmd(cmd))
        begin
            targetOk = 1'b1;
        end
        else if (cmd == ppb_pkg::CMD_CFG_RD)
        begin
            targetOk = (bus == ppb_pkg::BUS_PRIMARY);
        end
        else if (cmd == ppb_pkg::CMD_CFG_WR)
        begin
            targetOk = (bus == ppb_pkg::BUS_PRIMARY) || type1;
        end
        else
        begin
            targetOk = 1'b0;
        end
    endfunction : targetOk

    function automatic logic masterOk(input logic bus, input logic [3:0] cmd,
                                      input logic type1);
        if (fwdCmd(cmd) || (cmd == ppb_pkg::CMD_SPECIAL))
        begin
            masterOk = 1'b1;
        end
        else if (cmd == ppb_pkg::CMD_CFG_RD)
        begin
            masterOk = (bus == ppb_pkg::BUS_SECONDARY);
        end
        else if (cmd == ppb_pkg::CMD_CFG_WR)
        begin
            masterOk = (bus == ppb_pkg::BUS_SECONDARY) || type1;
        end
        else
        begin
            masterOk = 1'b0;
        end
    endfunction : masterOk

    // ************************************************************
    // Claim decisions
    // ************************************************************
    wire logic priInWin = (priDec.addr >= prefBase) && (priDec.addr <= prefLimit);
    wire logic secInWin = (secDec.addr >= prefBase) && (secDec.addr <= prefLimit);
    wire logic priDualOk = memCmd(priDec.cmd) && priInWin;
    wire logic secDualOk = memCmd(secDec.cmd) && !secInWin;
    wire logic priHit = priDec.done && (priDec.dual ? priDualOk
        : targetOk(ppb_pkg::BUS_PRIMARY, priDec.cmd, priDec.cfgType1));
    wire logic secHit = secDec.done && (secDec.dual ? secDualOk
        : targetOk(ppb_pkg::BUS_SECONDARY, secDec.cmd, secDec.cfgType1));
    wire logic issueOk = masterOk(issueBus, issueCmd, issueType1);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            priClaim <= 1'b0;
            priDisconnect <= 1'b0;
            priFwdDown <= 1'b0;
            secClaim <= 1'b0;
            secDisconnect <= 1'b0;
            secFwdUp <= 1'b0;
            claimCmd <= 4'h0;
            claimAddr <= 64'h0000_0000_0000_0000;
            specialOnPri <= 1'b0;
            specialOnSec <= 1'b0;
            issueGrant <= 1'b0;
            issueDeny <= 1'b0;
        end
        else
        begin
            priClaim <= priHit;
            priFwdDown <= priHit && priDec.dual;
            priDisconnect <= priHit && priDec.badBurst;
            secClaim <= secHit;
            secFwdUp <= secHit && secDec.dual;
            secDisconnect <= secHit && secDec.badBurst;
            if (priHit)
            begin
                claimCmd <= priDec.cmd;
                claimAddr <= priDec.addr;
            end
            else if (secHit)
            begin
                claimCmd <= secDec.cmd;
                claimAddr <= secDec.addr;
            end
            specialOnSec <= priHit && priDec.specialReq;
            specialOnPri <= secHit && secDec.specialReq;
            issueGrant <= issueReq && issueOk;
            issueDeny <= issueReq && !issueOk;
        end
    end

    // ************************************************************
    // Direction buffers
    // ************************************************************
    // One array for all four keeps a single read mux; costs dual porting
    logic [31:0] bufMem [ppb_pkg::BUF_COUNT][BUF_WORDS];

    always_ff @(posedge clk_sys)
    begin
        if (bufWrEn)
        begin
            bufMem[bufId][bufIndex] <= bufWrData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bufRdData <= 32'h0000_0000;
        end
        else
        begin
            bufRdData <= bufMem[bufId][bufIndex];
        end
    end
endmodule : ppb_bridge_decode
`default_nettype wire

/* tb/ppb_bridge_decode_monitor.sv */
// Concurrent checks on the ports of the bridge decode
`default_nettype none
module ppb_bridge_decode_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Issue check
    input wire logic issueReq,
    input wire logic issueBus,
    input wire logic [3:0] issueCmd,
    input wire logic issueType1,
    input wire logic issueGrant,
    input wire logic issueDeny,
    // Claims
    input wire logic priClaim,
    input wire logic priDisconnect,
    input wire logic priFwdDown,
    input wire logic secClaim,
    input wire logic secFwdUp,
    input wire logic [3:0] claimCmd,
    input wire logic specialOnSec
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    wire memCmd = claimCmd inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
    wire badCmd = claimCmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9};
    wire cfgDeny = !issueBus && (issueCmd == 4'hA || issueCmd == 4'hB && !issueType1);

    issue_answer_a: assert property (issueReq |=> issueGrant != issueDeny)
        else $error("issue request not answered once");
    stray_answer_a: assert property (issueGrant || issueDeny |-> $past(issueReq))
        else $error("answer without request");
    rsvd_deny_a: assert property (issueReq && issueCmd inside {4'h4, 4'h5, 4'h8, 4'h9} |=> issueDeny)
        else $error("reserved command granted");
    intack_deny_a: assert property (issueReq && issueCmd == 4'h0 |=> issueDeny)
        else $error("interrupt acknowledge granted");
    cfg_deny_a: assert property (issueReq && cfgDeny |=> issueDeny)
        else $error("config issue on primary granted");
    claim_legal_a: assert property (priClaim || secClaim |-> !badCmd)
        else $error("unsupported command claimed");
    disc_claim_a: assert property (priDisconnect |-> priClaim)
        else $error("disconnect without claim");
    fwd_down_a: assert property (priFwdDown |-> priClaim && memCmd)
        else $error("downstream forward without memory claim");
    fwd_up_a: assert property (secFwdUp |-> secClaim)
        else $error("upstream forward without claim");
    special_claim_a: assert property (specialOnSec |-> priClaim && claimCmd == 4'hB)
        else $error("special cycle without config write claim");
    cover property (priClaim && priFwdDown);
    cover property (secClaim && secFwdUp);
    cover property (specialOnSec);
endmodule : ppb_bridge_decode_monitor
bind ppb_bridge_decode ppb_bridge_decode_monitor mon (.clk_sys, .rst_n, .issueReq, .issueBus,
    .issueCmd, .issueType1, .issueGrant, .issueDeny, .priClaim, .priDisconnect, .priFwdDown,
    .secClaim, .secFwdUp, .claimCmd, .specialOnSec);
`default_nettype wire

/* tb/ppb_pci_init.sv */
// Behavioural initiator driving address phases on one bus
`default_nettype none
module ppb_pci_init (
    // Bus clock
    input wire logic clk,
    // Address phase pins
    output logic frameN,
    output logic [31:0] ad,
    output logic [3:0] cbeN
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        frameN = 1'b1;
        ad = 32'h0;
        cbeN = 4'hF;
    end
    // Released lines toggle so no stale address is ever seen
    task automatic drive(input logic dual, input logic [3:0] cmd, input logic [63:0] a);
        @(posedge clk);
        #1;
        frameN = 1'b0;
        ad = a[31:0];
        cbeN = dual ? ~ppb_pkg::CMD_DUAL_ADDR : ~cmd;
        if (dual)
        begin
            @(posedge clk);
            #1;
            ad = a[63:32];
            cbeN = ~cmd;
        end
        @(posedge clk);
        #1;
        ad = ~ad;
        cbeN = ~cbeN;
        @(posedge clk);
        #1;
        frameN = 1'b1;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            ad = ~ad;
        end
    endtask : drive
endmodule : ppb_pci_init
`default_nettype wire

/* tb/ppb_bridge_decode_tb.sv */
// Self-checking bench for the bridge command and address decode
`default_nettype none
`define CHK(a, b) \
    begin \
        compares++; \
        if ((a) !== (b) || $isunknown(b)) \
        begin \
            n_fail++; \
            $display("wrong value at %0t: got %h expected %h", $time, a, b); \
        end \
    end
module ppb_bridge_decode_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] BASE = 64'h0000_0001_0000_0000;
    localparam logic [63:0] LIMIT = 64'h0000_0001_FFFF_FFFC;
    localparam logic [3:0] MEM [5] = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
    logic clk_sys, rst_n, secClk, priFrameN, secFrameN, issueReq, issueBus, issueType1;
    logic bufWrEn, rdAsk, rdLate, issueGrant, issueDeny, priClaim, priDisconnect, priFwdDown;
    logic secClaim, secDisconnect, secFwdUp, specialOnPri, specialOnSec, g;
    logic [31:0] priAd, secAd, bufWrData, bufRdData, w;
    logic [31:0] wd [8];
    logic [3:0] priCbeN, secCbeN, issueCmd, claimCmd;
    logic [63:0] prefBase, prefLimit, claimAddr, a;
    logic [1:0] bufId;
    logic [4:0] bufIndex;
    logic [70:0] o, e, ex;
    logic [70:0] pq[$], sq[$];
    logic gq[$];
    logic [31:0] bq[$];
    int n_fail, compares;

    ppb_bridge_decode i_ppb_bridge_decode (.clk_sys, .rst_n, .priFrameN, .priAd, .priCbeN,
        .secondary_side_clock_in(secClk), .secFrameN, .secAd, .secCbeN, .prefBase, .prefLimit,
        .issueReq, .issueBus, .issueCmd, .issueType1, .issueGrant, .issueDeny, .priClaim,
        .priDisconnect, .priFwdDown, .secClaim, .secDisconnect, .secFwdUp, .claimCmd,
        .claimAddr, .specialOnPri, .specialOnSec, .bufWrEn, .bufId, .bufIndex, .bufWrData,
        .bufRdData);
    ppb_pci_init p_pri (.clk(clk_sys), .frameN(priFrameN), .ad(priAd), .cbeN(priCbeN));
    ppb_pci_init p_sec (.clk(secClk), .frameN(secFrameN), .ad(secAd), .cbeN(secCbeN));

    // ************************************************************
    // Clocks, drivers and result watcher
    // ************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Secondary much slower so each edge is seen by the oversampler
    initial
    begin
        secClk = 1'b0;
        #3;
        forever #20 secClk = ~secClk;
    end

    task automatic ask(input logic [5:0] i);
        @(posedge clk_sys);
        #1;
        issueReq = 1'b1;
        {issueBus, issueType1, issueCmd} = i;
        gq.push_back(!(i[3:0] inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9})
            && (i[3:0] != 4'hA || i[5]) && (i[3:0] != 4'hB || i[5] || i[4]));
    endtask : ask

    task automatic run(input logic bus, input logic dual, input logic [3:0] c,
                       input logic [63:0] ad);
        logic ok;
        logic [63:0] fa;
        fa = dual ? ad : {32'h0, ad[31:0]};
        case (c)
            4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD: ok = 1'b0;
            4'hA: ok = !bus;
            4'hB: ok = !bus || ad[1:0] == 2'h1;
            default: ok = 1'b1;
        endcase
        if (dual)
            ok = c inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF} && bus != (fa >= prefBase && fa <= prefLimit);
        e = {|ad[1:0] && c != 4'hB, dual, ok && c == 4'hB && ad[1:0] == 2'h1
            && ad[15:2] == ppb_pkg::CFG_SPECIAL_CODE, c, fa};
        if (ok && bus)
            sq.push_back(e);
        if (ok && !bus)
            pq.push_back(e);
        if (bus)
            p_sec.drive(dual, c, ad);
        else
            p_pri.drive(dual, c, ad);
    endtask : run

    // A result with no note left compares against unknown and fails
    always @(posedge clk_sys)
    begin
        if (rst_n && (issueGrant | issueDeny) !== 1'b0)
        begin
            g = gq.size() ? gq.pop_front() : 1'bx;
            `CHK({issueGrant, issueDeny}, {g, !g})
        end
        if (rst_n && priClaim !== 1'b0)
        begin
            o = {priDisconnect & claimCmd != 4'hB, priFwdDown, specialOnSec, claimCmd, claimAddr};
            ex = pq.size() ? pq.pop_front() : 'x;
            `CHK(o, ex)
        end
        if (rst_n && secClaim !== 1'b0)
        begin
            o = {secDisconnect & claimCmd != 4'hB, secFwdUp, specialOnPri, claimCmd, claimAddr};
            ex = sq.size() ? sq.pop_front() : 'x;
            `CHK(o, ex)
        end
        if (rdLate)
        begin
            w = bq.size() ? bq.pop_front() : 'x;
            `CHK(bufRdData, w)
        end
        rdLate = rdAsk;
    end

    task automatic end_of_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        end_of_test;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        void'($urandom(32'hAC74));
        {rst_n, issueReq, issueBus, issueType1, issueCmd, bufWrEn, rdAsk, rdLate} = '0;
        {bufId, bufIndex, bufWrData, n_fail, compares} = '0;
        prefBase = BASE;
        prefLimit = LIMIT;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 64; i++)
            ask(6'(i));
        @(posedge clk_sys);
        #1;
        issueReq = 1'b0;
        for (int k = 0; k < 32; k++)
        begin
            a = {$urandom, $urandom};
            if (k[3:1] == 3'h5)
                a[1:0] = {1'b0, k[0]};
            run(k[4], 1'b0, k[3:0], a);
        end
        for (int k = 0; k < 10; k++)
        begin
            a = k[1] ? (k[0] ? LIMIT : BASE) : (k[0] ? LIMIT + 64'h4 : BASE - 64'h4);
            run(1'b0, 1'b1, MEM[k % 5], a);
            run(1'b1, 1'b1, MEM[k % 5], a);
        end
        run(1'b0, 1'b1, 4'h3, BASE);
        run(1'b0, 1'b0, 4'hB, {48'h0, ppb_pkg::CFG_SPECIAL_CODE, 2'h1});
        run(1'b1, 1'b0, 4'hB, {48'h0, ppb_pkg::CFG_SPECIAL_CODE, 2'h1});
        run(1'b1, 1'b0, 4'hB, 64'h100);
        run(1'b0, 1'b0, 4'hB, 64'h100);
        for (int j = 0; j < 16; j++)
        begin
            @(posedge clk_sys);
            #1;
            bufWrEn = j < 8;
            rdAsk = j >= 8;
            bufId = j[1:0];
            bufIndex = j[2] ? 5'h1F : 5'h00;
            bufWrData = $urandom;
            if (j < 8)
                wd[j] = bufWrData;
            else
                bq.push_back(wd[j - 8]);
        end
        @(posedge clk_sys);
        #1;
        {bufWrEn, rdAsk} = 2'h0;
        repeat (40) @(posedge clk_sys);
        `CHK(pq.size() + sq.size() + gq.size() + bq.size(), 0)
        end_of_test;
    end
endmodule : ppb_bridge_decode_tb
`default_nettype wire
